/* core/gsl_regs.sv */
// Status, software lock, features and identity register bank
`include "gsl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module gsl_regs
  import gsl_pkg::*;
#(
  parameter logic       THREE_DIODE    = 1'b1,   // 1 for the three-diode variant
  parameter logic [7:0] PART_ID_SINGLE = 8'ha1,  // Arbitrary value
  parameter logic [7:0] PART_ID_TRIPLE = 8'ha3,  // Arbitrary value
  parameter logic [7:0] MAKER_ID       = 8'h3c,  // Arbitrary value
  parameter logic [7:0] REVISION_ID    = 8'h07   // Arbitrary value
)
(
  input  wire logic             clk_sys_i,       // 40 MHz system clock
  input  wire logic             reset_i,         // Hard reset, async, active high
  input  wire logic             clk_en_i,        // Clock enable, freezes all state when low
  input  wire gsl_pkg::gsl_req_t req_i,          // Register request from the serial bus logic
  input  wire logic [1:0]       gpio_pin_i,      // GPIO pin levels, asynchronous
  input  wire logic [1:0]       gpio_dir_out_i,  // 1 where the pin is an output
  input  wire logic [1:0]       gpio_int_en_i,   // Per-pin alert enable
  input  wire logic [2:0]       shutdown_select_code_i, // Shutdown-select pin code, asynchronous
  output var  gsl_pkg::gsl_rsp_t rsp_o,          // Read answer
  output logic                  gpio_summary_o,  // GPIO summary bit of main status
  output logic                  alert_o,         // Alert request, sticky until status read
  output logic                  lock_protected_o // Lock state for other protected registers
);
  import gsl_pkg::*;

  localparam int NP = `GSL_NUM_PINS;
  localparam logic [7:0] LOCK_RST = `GSL_RST_SOFTWARE_WRITE_LOCK;

  logic [NP-1:0] pin_meta_reg;
  logic [NP-1:0] pin_sync_reg;
  logic [NP-1:0] pin_last_reg;
  logic          pin_valid_reg;
  logic [1:0]    pin_fill_reg;
  logic [2:0]    sel_meta_reg;
  logic [2:0]    sel_sync_reg;
  logic          sel_taken_reg;
  logic [NP-1:0] change_status_reg;
  logic [NP-1:0] change_status_next;
  logic [NP-1:0] pin_event;
  logic [NP-1:0] alert_event;
  logic          lock_reg;
  logic [7:0]    features_reg;
  logic          alert_reg;
  gsl_rsp_t      rsp_reg;
  logic          status_read;
  logic          lock_write;
  logic [7:0]    read_mux;

  // Two-stage synchronisers for pins and straps
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      sel_meta_reg <= 3'h0;
      sel_sync_reg <= 3'h0;
    end
    else if (clk_en_i)
    begin
      pin_meta_reg <= gpio_pin_i;
      pin_sync_reg <= pin_meta_reg;
      sel_meta_reg <= shutdown_select_code_i;
      sel_sync_reg <= sel_meta_reg;
    end
  end

  // Previous pin level; detection waits until synchroniser and last sample hold real pin data
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pin_last_reg  <= '0;
      pin_fill_reg  <= 2'h0;
      pin_valid_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      pin_last_reg  <= pin_sync_reg;
      pin_fill_reg  <= {pin_fill_reg[0], 1'b1};
      pin_valid_reg <= pin_fill_reg[1];
    end
  end

  assign status_read = req_i.rd && (req_i.addr == `GSL_ADDR_GPIO_CHANGE_STATUS);

  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_pin
      // Both edges count, only while the pin is an input; enable not consulted
      assign pin_event[g] = pin_valid_reg && !gpio_dir_out_i[g]
                            && (pin_sync_reg[g] != pin_last_reg[g]);
      assign alert_event[g] = pin_event[g] && gpio_int_en_i[g];
      // Set wins over the clearing read
      assign change_status_next[g] = pin_event[g]
                                     || (change_status_reg[g] && !status_read);
    end
  endgenerate

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      change_status_reg <= NP'(`GSL_RST_GPIO_CHANGE_STATUS);
    else if (clk_en_i)
      change_status_reg <= change_status_next;
  end

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      gpio_summary_o <= 1'b0;
    else if (clk_en_i)
      gpio_summary_o <= |change_status_next;
  end

  // Alert held until the status register is read, new events win
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      alert_reg <= 1'b0;
    else if (clk_en_i)
      alert_reg <= (|alert_event) || (alert_reg && !status_read);
  end

  assign alert_o = alert_reg;

  // Lock register is itself protected, so a set lock can never be written back
  assign lock_write = req_i.wr && (req_i.addr == `GSL_ADDR_SOFTWARE_WRITE_LOCK)
                      && !lock_reg;

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      lock_reg <= LOCK_RST[`GSL_LOCK_BIT];
    else if (clk_en_i && lock_write)
      lock_reg <= req_i.wdata[`GSL_LOCK_BIT];
  end

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      lock_protected_o <= 1'b0;
    else if (clk_en_i)
      lock_protected_o <= lock_write ? req_i.wdata[`GSL_LOCK_BIT] : lock_reg;
  end

  // Strap captured once, on the first enabled cycle after synchroniser fill
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      features_reg  <= `GSL_RST_PIN_SELECTED_FEATURES;
      sel_taken_reg <= 1'b0;
    end
    else if (clk_en_i && pin_valid_reg && !sel_taken_reg)
    begin
      features_reg  <= {5'h00, sel_sync_reg};
      sel_taken_reg <= 1'b1;
    end
  end

  always_comb
  begin
    read_mux = 8'h00;
    unique case (req_i.addr)
      `GSL_ADDR_GPIO_CHANGE_STATUS:   read_mux = {6'h00, change_status_reg};
      `GSL_ADDR_SOFTWARE_WRITE_LOCK:  read_mux = {7'h00, lock_reg};
      `GSL_ADDR_PIN_SELECTED_FEATURES: read_mux = features_reg;
      `GSL_ADDR_PART_IDENTITY:        read_mux = THREE_DIODE ? PART_ID_TRIPLE
                                                             : PART_ID_SINGLE;
      `GSL_ADDR_MAKER_IDENTITY:       read_mux = MAKER_ID;
      `GSL_ADDR_DIE_REVISION:         read_mux = REVISION_ID;
      default:                        read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      rsp_reg <= '0;
    else if (clk_en_i)
    begin
      rsp_reg.valid <= req_i.rd;
      rsp_reg.rdata <= req_i.rd ? read_mux : 8'h00;
    end
  end

  assign rsp_o = rsp_reg;

  AST_READ_CLEARS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && status_read && !(|pin_event) |=> change_status_reg == '0)
    else $error("status not cleared by read");

  AST_STICKY: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && !status_read && change_status_reg[0] |=> change_status_reg[0])
    else $error("status bit lost without read");

  AST_EVENT_SETS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && pin_event[1] |=> change_status_reg[1])
    else $error("pin change not recorded");

  AST_SUMMARY: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    gpio_summary_o == (|change_status_reg))
    else $error("summary disagrees with status");

  AST_OUTPUT_IGNORED: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && gpio_dir_out_i[0] && !status_read && !change_status_reg[0]
    |=> !change_status_reg[0])
    else $error("output pin set status");

  AST_LOCK_HOLDS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    lock_reg |=> lock_reg)
    else $error("lock cleared without reset");

  AST_LOCKED_WRITE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    lock_reg && req_i.wr |=> lock_protected_o && lock_reg)
    else $error("write accepted while locked");

  AST_UNLOCKED_WRITE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && !lock_reg && req_i.wr && req_i.addr == `GSL_ADDR_SOFTWARE_WRITE_LOCK
    |=> lock_reg == $past(req_i.wdata[0]))
    else $error("unlocked write not taken");

  AST_RACE_KEPT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && status_read && pin_event[0] |=> change_status_reg[0] ##1 1'b1)
    else $error("coincident change lost");

  AST_ALERT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && alert_event[0] |=> alert_o)
    else $error("alert not raised");

  AST_IDENTITY: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && req_i.rd && req_i.addr == `GSL_ADDR_MAKER_IDENTITY
    |=> rsp_o.valid && rsp_o.rdata == MAKER_ID)
    else $error("maker identity wrong");

  // Checks on both pins, the freeze, the alert, the lock flag, the features and the read answers

  AST_FREEZE_STATUS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !clk_en_i
    |=> $stable(change_status_reg))
    else $error("status moved while frozen");

  AST_FREEZE_LOCK: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !clk_en_i
    |=> $stable(lock_reg))
    else $error("lock moved while frozen");

  AST_EVENT_SETS_ONE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && pin_event[0]
    |=> change_status_reg[0])
    else $error("pin one change not recorded");

  AST_STICKY_TWO: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && !status_read && change_status_reg[1]
    |=> change_status_reg[1])
    else $error("pin two status lost without read");

  AST_OUTPUT_IGNORED_TWO: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && gpio_dir_out_i[1] && !status_read && !change_status_reg[1]
    |=> !change_status_reg[1])
    else $error("output pin two set status");

  AST_NO_SPURIOUS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && !(|pin_event)
    |=> (change_status_reg & ~$past(change_status_reg)) == '0)
    else $error("status set without pin change");

  AST_RACE_KEPT_TWO: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && status_read && pin_event[1]
    |=> change_status_reg[1])
    else $error("coincident pin two change lost");

  AST_ALERT_TWO: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && alert_event[1]
    |=> alert_o)
    else $error("pin two alert not raised");

  AST_ALERT_MASKED: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && !alert_o && !(|alert_event)
    |=> !alert_o)
    else $error("alert raised without enabled change");

  AST_LOCK_FLAG: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    lock_protected_o == lock_reg)
    else $error("lock flag disagrees with lock");

  AST_UNLOCKED_FLAG: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && !lock_reg && req_i.wr && req_i.addr == `GSL_ADDR_SOFTWARE_WRITE_LOCK
    |=> lock_protected_o == $past(req_i.wdata[0]))
    else $error("lock flag missed unlocked write");

  AST_FEATURES_UPPER: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && req_i.rd && req_i.addr == `GSL_ADDR_PIN_SELECTED_FEATURES
    |=> rsp_o.valid && rsp_o.rdata[7:3] == 5'h00)
    else $error("features upper bits set");

  AST_FEATURES_FROZEN: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    sel_taken_reg
    |=> $stable(features_reg))
    else $error("features changed after capture");

  AST_PART_ID: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && req_i.rd && req_i.addr == `GSL_ADDR_PART_IDENTITY
    |=> rsp_o.valid && rsp_o.rdata == (THREE_DIODE ? PART_ID_TRIPLE : PART_ID_SINGLE))
    else $error("part identity wrong");

  AST_REVISION: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && req_i.rd && req_i.addr == `GSL_ADDR_DIE_REVISION
    |=> rsp_o.valid && rsp_o.rdata == REVISION_ID)
    else $error("revision wrong");

  AST_STATUS_DATA: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && status_read
    |=> rsp_o.valid && rsp_o.rdata == {6'h00, $past(change_status_reg)})
    else $error("status read data wrong");

  AST_RSP_IDLE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && !req_i.rd
    |=> !rsp_o.valid && rsp_o.rdata == 8'h00)
    else $error("answer without read");

  AST_SUMMARY_RISE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clk_en_i && (|pin_event)
    |=> gpio_summary_o)
    else $error("summary not raised by change");
endmodule
`default_nettype wire

/* core/gsl_params.svh */
// Register offsets, field positions and reset values of the status, lock and identity bank
`ifndef GSL_PARAMS_SVH
`define GSL_PARAMS_SVH
`define GSL_ADDR_GPIO_CHANGE_STATUS   8'he6
`define GSL_ADDR_SOFTWARE_WRITE_LOCK  8'hef
`define GSL_ADDR_PIN_SELECTED_FEATURES 8'hfc
`define GSL_ADDR_PART_IDENTITY        8'hfd
`define GSL_ADDR_MAKER_IDENTITY       8'hfe
`define GSL_ADDR_DIE_REVISION         8'hff
`define GSL_RST_GPIO_CHANGE_STATUS    8'h00
`define GSL_RST_SOFTWARE_WRITE_LOCK   8'h00
`define GSL_RST_PIN_SELECTED_FEATURES 8'h00
`define GSL_LOCK_BIT                  0
`define GSL_PIN_ONE_BIT               0
`define GSL_PIN_TWO_BIT               1
`define GSL_SEL_MSB                   2
`define GSL_NUM_PINS                  2
`endif

/* core/gsl_pkg.sv */
// Types shared by the status, lock and identity register bank
package gsl_pkg;
  typedef struct packed {
    logic       wr;     // Write strobe, one cycle
    logic       rd;     // Read strobe, one cycle
    logic [7:0] addr;   // Register offset
    logic [7:0] wdata;  // Write data
  } gsl_req_t;

  typedef struct packed {
    logic       valid;  // Read data valid, one cycle
    logic [7:0] rdata;  // Read data
  } gsl_rsp_t;

  typedef enum logic [2:0] {
    GSL_EXT1_SIMPLE     = 3'h0,
    GSL_EXT1_DIODE      = 3'h1,
    GSL_EXT1_TRANSISTOR = 3'h2,
    GSL_INT_TRANSISTOR  = 3'h3,
    GSL_EXT2_OR_EXT1D   = 3'h4,
    GSL_EXT1_TRANS_ALT  = 3'h5
  } gsl_diode_mode_t;
endpackage

/* verification/gsl_host_model.sv */
// Host model issuing register reads and writes on the request port
`timescale 1ns/1ps
`default_nettype none
module gsl_host_model
  import gsl_pkg::*;
(
  input  wire logic              clk_sys_i, // System clock
  input  wire gsl_pkg::gsl_rsp_t rsp_i,     // Read answer
  output var  gsl_pkg::gsl_req_t req_o      // Register request
);
  initial req_o = '0;

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_sys_i);
    req_o <= '0;
  endtask

  // Read answer sampled 1 ns after the edge that takes the request; missing answer reads unknown
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys_i);
    req_o <= '0;
    #1;
    v = (rsp_i.valid === 1'b1) ? rsp_i.rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire

/* verification/test_gsl_regs.sv */
// Self-checking bench for the status, lock and identity register bank
`timescale 1ns/1ps
`default_nettype none
module test_gsl_regs;
  import gsl_pkg::*;
  localparam logic [7:0] PID = 8'h6b; // Arbitrary value
  localparam logic [7:0] MID = 8'h42; // Arbitrary value
  localparam logic [7:0] RID = 8'h09; // Arbitrary value
  logic       clk_sys = 1'b0;
  logic       reset   = 1'b1;
  logic [1:0] pin     = 2'h0;
  logic [1:0] dir     = 2'h0;
  logic [1:0] ien     = 2'h0;
  logic [2:0] sel     = 3'h0;
  logic       en      = 1'b1;
  gsl_req_t   req;
  gsl_rsp_t   rsp;
  logic       summary, alert, locked;
  logic [7:0] d, e;
  int         failures = 0, n_checks = 0, cycles = 0;

  always #12.5 clk_sys = ~clk_sys;

  gsl_host_model host_u (.clk_sys_i(clk_sys), .rsp_i(rsp), .req_o(req));
  gsl_regs #(.PART_ID_TRIPLE(PID), .MAKER_ID(MID), .REVISION_ID(RID)) dut_u (
    .clk_sys_i(clk_sys), .reset_i(reset), .clk_en_i(en), .req_i(req), .gpio_pin_i(pin),
    .gpio_dir_out_i(dir), .gpio_int_en_i(ien), .shutdown_select_code_i(sel), .rsp_o(rsp),
    .gpio_summary_o(summary), .alert_o(alert), .lock_protected_o(locked));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic toggle(input int b, input int k);
    @(posedge clk_sys);
    pin[b] <= ~pin[b];
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic t_ident();
    host_u.rd(8'he6, d);
    chk("status reset", 8'h00, d);
    host_u.wr(8'hfd, 8'h00);
    host_u.rd(8'hfd, d);
    chk("part id", PID, d);
    host_u.rd(8'hfe, d);
    chk("maker id", MID, d);
    host_u.rd(8'hff, d);
    chk("revision", RID, d);
    host_u.rd(8'h10, d);
    chk("unmapped", 8'h00, d);
    $display("test ident done");
  endtask

  task automatic t_status();
    toggle(0, 6);
    chk("summary set", 8'h01, {7'h0, summary});
    chk("alert masked", 8'h00, {7'h0, alert});
    host_u.rd(8'he6, d);
    chk("status pin one", 8'h01, d);
    host_u.rd(8'he6, d);
    chk("status cleared", 8'h00, d);
    chk("summary clear", 8'h00, {7'h0, summary});
    @(posedge clk_sys);
    ien <= 2'h2;
    dir <= 2'h1;
    toggle(0, 6);
    toggle(1, 6);
    chk("alert raised", 8'h01, {7'h0, alert});
    host_u.rd(8'he6, d);
    chk("status pin two", 8'h02, d);
    chk("alert cleared", 8'h00, {7'h0, alert});
    @(posedge clk_sys);
    dir <= 2'h0;
    $display("test status done");
  endtask

  task automatic t_coincide();
    for (int k = 0; k < 5; k++)
    begin
      toggle(0, k);
      host_u.rd(8'he6, d);
      repeat (6) @(posedge clk_sys);
      host_u.rd(8'he6, e);
      chk("change kept", 8'h01, (d | e) & 8'h01);
      chk("single report", 8'h00, d & e);
    end
    $display("test coincide done");
  endtask

  task automatic t_freeze();
    @(posedge clk_sys);
    en <= 1'b0;
    toggle(0, 6);
    chk("frozen summary", 8'h00, {7'h0, summary});
    @(posedge clk_sys);
    en <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    chk("thawed summary", 8'h01, {7'h0, summary});
    host_u.rd(8'he6, d);
    chk("thawed status", 8'h01, d);
    $display("test freeze done");
  endtask

  task automatic t_lock();
    host_u.wr(8'hef, 8'h01);
    host_u.rd(8'hef, d);
    chk("lock set", 8'h01, d);
    chk("lock flag", 8'h01, {7'h0, locked});
    host_u.wr(8'hef, 8'h00);
    host_u.rd(8'hef, d);
    chk("lock kept", 8'h01, d);
    $display("test lock done");
  endtask

  task automatic t_features();
    for (int c = 0; c < 6; c++)
    begin
      @(posedge clk_sys);
      sel <= c[2:0];
      do_reset();
      host_u.rd(8'hfc, d);
      chk("features", {5'h0, c[2:0]}, d);
      host_u.rd(8'hef, d);
      chk("lock after reset", 8'h00, d);
    end
    $display("test features done");
  endtask

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures++;
      wrap_up();
    end
  end

  initial
  begin
    do_reset();
    t_ident();
    t_status();
    t_coincide();
    t_freeze();
    t_lock();
    t_features();
    wrap_up();
  end
endmodule
`default_nettype wire
